//--- bsdr_pkg.sv
// Shared constants for the boundary-scan test data registers
`default_nettype none
package bsdr_pkg;
    // Register widths
    localparam int CHAIN_W = 40;
    localparam int CTRL_W  = 11;
    localparam int INSTR_W = 8;
    localparam int PINS_W  = 8;

    // Boundary cell chain bit map
    localparam int CH_B_DRV   = 39;
    localparam int CH_A_DRV   = 38;
    localparam int CH_CTRL_LO = 32;
    localparam int CH_AI_LO   = 24;
    localparam int CH_AO_LO   = 16;
    localparam int CH_BI_LO   = 8;
    localparam int CH_BO_LO   = 0;
    localparam int CTRL_PINS  = 6;

    // Run-test control layout
    localparam int RTC_MASK_LO = 3;
    localparam int RTC_OP_LO   = 0;
    localparam int RTC_OP_W    = 3;

    // Reset and capture values
    localparam logic [CHAIN_W-1:0] CHAIN_RST   = 40'h00_0000_0000;
    localparam logic [CTRL_W-1:0]  CTRL_RST    = 11'h002;
    localparam logic [INSTR_W-1:0] INSTR_RST   = 8'hff;
    localparam logic [INSTR_W-1:0] INSTR_CAPT  = 8'h81;

    // Instruction opcodes
    localparam logic [INSTR_W-1:0] OP_EXTEST    = 8'h00;
    localparam logic [INSTR_W-1:0] OP_INTEST    = 8'h03;
    localparam logic [INSTR_W-1:0] OP_SAMPLE    = 8'h82;
    localparam logic [INSTR_W-1:0] OP_HIGHZ     = 8'h06;
    localparam logic [INSTR_W-1:0] OP_CLAMP     = 8'h87;
    localparam logic [INSTR_W-1:0] OP_RUN_BT    = 8'h09;
    localparam logic [INSTR_W-1:0] OP_READ_NRM  = 8'h0a;
    localparam logic [INSTR_W-1:0] OP_READ_TST  = 8'h8b;
    localparam logic [INSTR_W-1:0] OP_SELFCHK   = 8'h0c;
    localparam logic [INSTR_W-1:0] OP_TOGGLE    = 8'h8d;
    localparam logic [INSTR_W-1:0] OP_CTRL_NRM  = 8'h8e;
    localparam logic [INSTR_W-1:0] OP_CTRL_TST  = 8'h0f;

    // Run-test operation codes (low two bits unless all three op bits high)
    localparam logic [1:0] RT_TOGGLE = 2'h0;
    localparam logic [1:0] RT_PRPG   = 2'h1;
    localparam logic [1:0] RT_PSA    = 2'h2;

    typedef enum logic [1:0] {
        BSDR_SEL_BYPASS = 2'h0,
        BSDR_SEL_CHAIN  = 2'h1,
        BSDR_SEL_CTRL   = 2'h3
    } bsdr_sel_e;

    typedef enum logic [1:0] {
        BSDR_MODE_NORMAL = 2'h0,
        BSDR_MODE_TEST   = 2'h1,
        BSDR_MODE_HIGHZ  = 2'h3
    } bsdr_mode_e;

    typedef enum logic [1:0] {
        BSDR_CAP_NONE = 2'h0,
        BSDR_CAP_EXT  = 2'h1,
        BSDR_CAP_INV  = 2'h3
    } bsdr_cap_e;
endpackage
`default_nettype wire

//--- bsdr_scan_reg.sv
// Shift stage with shadow latch, used for the instruction, chain and control registers
`timescale 1ns/1ps
`default_nettype none
module bsdr_scan_reg #(
    parameter int           W      = 8,
    parameter logic [W-1:0] SH_RST = '0,
    parameter logic [W-1:0] UP_RST = '0
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic         clear_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_data_i,
    input  wire logic         shift_i,
    input  wire logic         sin_i,
    input  wire logic         update_i,
    output logic      [W-1:0] shift_q_o,
    output logic      [W-1:0] shadow_q_o
);
    // A one-bit shift cannot keep the {sin, q[W-1:1]} form
    if (W < 2) begin : g_bad_width
        $error("bsdr_scan_reg needs W of at least 2");
    end

    logic [W-1:0] shift_reg;
    logic [W-1:0] shift_next;
    logic [W-1:0] shadow_reg;
    logic [W-1:0] shadow_next;

    // Clear beats load, load beats shift; shift enters at the top bit
    always_comb begin
        shift_next  = shift_reg;
        shadow_next = shadow_reg;
        if (clear_i) begin
            shift_next  = SH_RST;
            shadow_next = UP_RST;
        end else begin
            if (load_i) begin
                shift_next = load_data_i;
            end else if (shift_i) begin
                shift_next = {sin_i, shift_reg[W-1:1]};
            end
            if (update_i) begin
                shadow_next = shift_reg;
            end
        end
    end

    // Storage only
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            shift_reg  <= SH_RST;
            shadow_reg <= UP_RST;
        end else begin
            shift_reg  <= shift_next;
            shadow_reg <= shadow_next;
        end
    end

    assign shift_q_o  = shift_reg;
    assign shadow_q_o = shadow_reg;
endmodule
`default_nettype wire

//--- bsdr_top.sv
// Boundary-scan data registers, instruction decode and pin/core muxing
`timescale 1ns/1ps
`default_nettype none
module bsdr_top #(
    parameter int PINS = bsdr_pkg::PINS_W
) (
    input  wire logic            mclk_i,
    input  wire logic            rst_i,
    input  wire logic            tck_rise_i,
    input  wire logic            tck_fall_i,
    input  wire logic            tlr_i,
    input  wire logic            rti_i,
    input  wire logic            cap_dr_i,
    input  wire logic            sh_dr_i,
    input  wire logic            upd_dr_i,
    input  wire logic            cap_ir_i,
    input  wire logic            sh_ir_i,
    input  wire logic            upd_ir_i,
    input  wire logic            tdi_i,
    output logic                 tdo_o,
    output logic                 tdo_oe_o,
    input  wire logic            ab_output_enable_n_i,
    input  wire logic            ba_output_enable_n_i,
    input  wire logic            ab_latch_enable_n_i,
    input  wire logic            ba_latch_enable_n_i,
    input  wire logic            ab_chip_enable_n_i,
    input  wire logic            ba_chip_enable_n_i,
    input  wire logic [PINS-1:0] a_pin_i,
    output logic      [PINS-1:0] a_pin_o,
    output logic      [PINS-1:0] a_pin_oe_o,
    input  wire logic [PINS-1:0] b_pin_i,
    output logic      [PINS-1:0] b_pin_o,
    output logic      [PINS-1:0] b_pin_oe_o,
    input  wire logic [PINS-1:0] core_a_out_i,
    input  wire logic [PINS-1:0] core_b_out_i,
    output logic      [PINS-1:0] core_a_o,
    output logic      [PINS-1:0] core_b_o,
    output logic      [5:0]      core_ctrl_o
);
    // The chain bit map is fixed at eight data pins per side
    if (PINS != bsdr_pkg::PINS_W) begin : g_bad_pins
        $error("bsdr_top supports only eight pins per side");
    end

    localparam int CW = bsdr_pkg::CHAIN_W;
    localparam int RW = bsdr_pkg::CTRL_W;
    localparam int IW = bsdr_pkg::INSTR_W;

    logic [CW-1:0] chain_sh, chain_q, chain_load;
    logic [RW-1:0] ctrl_sh, ctrl_q;
    logic [IW-1:0] instr_sh, instr_q;
    logic          chain_ld, chain_up, byp_reg, byp_next;
    logic          tdo_reg, tdo_next, tdo_oe_reg, tdo_oe_next;
    bsdr_pkg::bsdr_sel_e  sel;
    bsdr_pkg::bsdr_mode_e mode;
    bsdr_pkg::bsdr_cap_e  cap_kind;
    logic          run_bt, toggle_only;
    logic          oea_eq, oeb_eq, ab_flow, one_dir, run_act;
    logic [PINS-1:0] in_cells, out_cells, in_pins, in_mask, in_next, out_next;
    logic [1:0]      rt_op;
    logic [PINS-1:0] a_pin_next, a_oe_next, b_pin_next, b_oe_next, core_a_next, core_b_next;
    logic [5:0]      core_ctrl_next;
    logic [PINS-1:0] a_pin_reg, a_oe_reg, b_pin_reg, b_oe_reg, core_a_reg, core_b_reg;
    logic [5:0]      core_ctrl_reg;
    logic [5:0]      ctrl_pins;

    bsdr_scan_reg #(.W(IW), .SH_RST(bsdr_pkg::INSTR_RST), .UP_RST(bsdr_pkg::INSTR_RST)) u_instr (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .clear_i     (tlr_i),
        .load_i      (tck_rise_i & cap_ir_i),
        .load_data_i (bsdr_pkg::INSTR_CAPT),
        .shift_i     (tck_rise_i & sh_ir_i),
        .sin_i       (tdi_i),
        .update_i    (tck_fall_i & upd_ir_i),
        .shift_q_o   (instr_sh),
        .shadow_q_o  (instr_q)
    );

    // opcodes are taken whole; parity lives in the table itself
    always_comb begin
        sel         = bsdr_pkg::BSDR_SEL_BYPASS;
        mode        = bsdr_pkg::BSDR_MODE_NORMAL;
        cap_kind    = bsdr_pkg::BSDR_CAP_NONE;
        run_bt      = 1'b0;
        toggle_only = 1'b0;
        case (instr_q)
            bsdr_pkg::OP_EXTEST, bsdr_pkg::OP_INTEST: begin
                sel      = bsdr_pkg::BSDR_SEL_CHAIN;
                mode     = bsdr_pkg::BSDR_MODE_TEST;
                cap_kind = bsdr_pkg::BSDR_CAP_EXT;
            end
            bsdr_pkg::OP_SAMPLE: begin
                sel      = bsdr_pkg::BSDR_SEL_CHAIN;
                cap_kind = bsdr_pkg::BSDR_CAP_EXT;
            end
            bsdr_pkg::OP_HIGHZ:    mode = bsdr_pkg::BSDR_MODE_HIGHZ;
            bsdr_pkg::OP_CLAMP:    mode = bsdr_pkg::BSDR_MODE_TEST;
            bsdr_pkg::OP_RUN_BT: begin
                mode   = bsdr_pkg::BSDR_MODE_TEST;
                run_bt = 1'b1;
            end
            bsdr_pkg::OP_READ_NRM: sel = bsdr_pkg::BSDR_SEL_CHAIN;
            bsdr_pkg::OP_READ_TST: begin
                sel  = bsdr_pkg::BSDR_SEL_CHAIN;
                mode = bsdr_pkg::BSDR_MODE_TEST;
            end
            bsdr_pkg::OP_SELFCHK: begin
                sel      = bsdr_pkg::BSDR_SEL_CHAIN;
                cap_kind = bsdr_pkg::BSDR_CAP_INV;
            end
            bsdr_pkg::OP_TOGGLE: begin
                mode        = bsdr_pkg::BSDR_MODE_TEST;
                toggle_only = 1'b1;
            end
            bsdr_pkg::OP_CTRL_NRM: sel = bsdr_pkg::BSDR_SEL_CTRL;
            bsdr_pkg::OP_CTRL_TST: begin
                sel  = bsdr_pkg::BSDR_SEL_CTRL;
                mode = bsdr_pkg::BSDR_MODE_TEST;
            end
            default: begin
                sel  = bsdr_pkg::BSDR_SEL_BYPASS;
                mode = bsdr_pkg::BSDR_MODE_NORMAL;
            end
        endcase
    end

    // decoded drive enables, as the equation is written
    assign oea_eq    = ~ba_output_enable_n_i | ~ba_chip_enable_n_i;
    assign oeb_eq    = ~ab_output_enable_n_i | ~ab_chip_enable_n_i;
    assign ctrl_pins = {ab_output_enable_n_i, ba_output_enable_n_i, ab_latch_enable_n_i,
                        ba_latch_enable_n_i, ab_chip_enable_n_i, ba_chip_enable_n_i};

    // Direction from the drive-enable cells; both or neither means no run
    assign ab_flow   = ~chain_q[bsdr_pkg::CH_A_DRV] & chain_q[bsdr_pkg::CH_B_DRV];
    assign one_dir   = chain_q[bsdr_pkg::CH_A_DRV] ^ chain_q[bsdr_pkg::CH_B_DRV];
    assign rt_op     = ctrl_q[bsdr_pkg::RTC_OP_LO +: 2];
    assign in_mask   = ctrl_q[bsdr_pkg::RTC_MASK_LO +: PINS];
    assign in_cells  = ab_flow ? chain_sh[bsdr_pkg::CH_AI_LO +: PINS] : chain_sh[bsdr_pkg::CH_BI_LO +: PINS];
    assign out_cells = ab_flow ? chain_sh[bsdr_pkg::CH_BO_LO +: PINS] : chain_sh[bsdr_pkg::CH_AO_LO +: PINS];
    assign in_pins   = ab_flow ? a_pin_i : b_pin_i;
    // control settings only count under run boundary test
    assign run_act   = rti_i & one_dir & (run_bt | toggle_only);

    // Simplified run-test steps: sample/toggle, 8-bit pattern, masked signature, count
    always_comb begin
        in_next  = in_cells;
        out_next = out_cells;
        if (toggle_only) begin
            out_next = ~out_cells;
        end else if (ctrl_q[bsdr_pkg::RTC_OP_LO +: bsdr_pkg::RTC_OP_W] == 3'h7) begin
            out_next = out_cells + 8'h01;
            in_next  = {in_cells[6:0], in_cells[7]} ^ (in_pins & ~in_mask);
        end else if (rt_op == bsdr_pkg::RT_TOGGLE) begin
            out_next = ~out_cells;
            in_next  = in_pins;
        end else begin
            // mask bits 10..3 gate pins 8..1 out of the signature
            if (rt_op != bsdr_pkg::RT_PRPG) begin
                in_next = {in_cells[6:0], in_cells[7]} ^ (in_pins & ~in_mask);
            end
            if (rt_op != bsdr_pkg::RT_PSA) begin
                out_next = {out_cells[6:0], out_cells[7] ^ out_cells[5] ^ out_cells[4] ^ out_cells[3]};
            end
        end
    end

    // chain load source: capture or run-test step
    always_comb begin
        chain_load = chain_sh;
        chain_ld   = 1'b0;
        if (tck_rise_i & cap_dr_i & (sel == bsdr_pkg::BSDR_SEL_CHAIN)) begin
            if (cap_kind == bsdr_pkg::BSDR_CAP_EXT) begin
                // inputs from pins, outputs from core
                chain_load = {oeb_eq, oea_eq, ctrl_pins, a_pin_i, core_a_out_i, b_pin_i, core_b_out_i};
                chain_ld   = 1'b1;
            end else if (cap_kind == bsdr_pkg::BSDR_CAP_INV) begin
                chain_load = ~chain_q;
                chain_ld   = 1'b1;
            end
        end else if (tck_rise_i & run_act) begin
            chain_ld = 1'b1;
            if (ab_flow) begin
                chain_load[bsdr_pkg::CH_AI_LO +: PINS] = in_next;
                chain_load[bsdr_pkg::CH_BO_LO +: PINS] = out_next;
            end else begin
                chain_load[bsdr_pkg::CH_BI_LO +: PINS] = in_next;
                chain_load[bsdr_pkg::CH_AO_LO +: PINS] = out_next;
            end
        end
    end
    assign chain_up = tck_fall_i & ((upd_dr_i & (sel == bsdr_pkg::BSDR_SEL_CHAIN)) | run_act);

    bsdr_scan_reg #(.W(CW), .SH_RST(bsdr_pkg::CHAIN_RST), .UP_RST(bsdr_pkg::CHAIN_RST)) u_chain (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .clear_i     (tlr_i),
        .load_i      (chain_ld),
        .load_data_i (chain_load),
        .shift_i     (tck_rise_i & sh_dr_i & (sel == bsdr_pkg::BSDR_SEL_CHAIN)),
        .sin_i       (tdi_i),
        .update_i    (chain_up),
        .shift_q_o   (chain_sh),
        .shadow_q_o  (chain_q)
    );

    // control register never loads at capture
    bsdr_scan_reg #(.W(RW), .SH_RST(bsdr_pkg::CTRL_RST), .UP_RST(bsdr_pkg::CTRL_RST)) u_ctrl (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .clear_i     (tlr_i),
        .load_i      (1'b0),
        .load_data_i (bsdr_pkg::CTRL_RST),
        .shift_i     (tck_rise_i & sh_dr_i & (sel == bsdr_pkg::BSDR_SEL_CTRL)),
        .sin_i       (tdi_i),
        .update_i    (tck_fall_i & upd_dr_i & (sel == bsdr_pkg::BSDR_SEL_CTRL)),
        .shift_q_o   (ctrl_sh),
        .shadow_q_o  (ctrl_q)
    );

    // bypass stage and TDO, which changes on the falling edge
    always_comb begin
        byp_next    = byp_reg;
        tdo_next    = tdo_reg;
        tdo_oe_next = tdo_oe_reg;
        if (tck_rise_i & (sel == bsdr_pkg::BSDR_SEL_BYPASS)) begin
            if (cap_dr_i) begin
                byp_next = 1'b0;
            end else if (sh_dr_i) begin
                byp_next = tdi_i;
            end
        end
        if (tck_fall_i) begin
            tdo_oe_next = sh_dr_i | sh_ir_i;
            if (sh_ir_i) begin
                tdo_next = instr_sh[0];
            end else if (sel == bsdr_pkg::BSDR_SEL_CHAIN) begin
                tdo_next = chain_sh[0];
            end else if (sel == bsdr_pkg::BSDR_SEL_CTRL) begin
                tdo_next = ctrl_sh[0];
            end else begin
                tdo_next = byp_reg;
            end
        end
    end

    // pin and core muxing by mode
    always_comb begin
        a_pin_next     = core_a_out_i;
        b_pin_next     = core_b_out_i;
        a_oe_next      = {PINS{oea_eq}};
        b_oe_next      = {PINS{oeb_eq}};
        core_a_next    = a_pin_i;
        core_b_next    = b_pin_i;
        core_ctrl_next = ctrl_pins;
        if (mode == bsdr_pkg::BSDR_MODE_TEST) begin
            a_pin_next     = chain_q[bsdr_pkg::CH_AO_LO +: PINS];
            b_pin_next     = chain_q[bsdr_pkg::CH_BO_LO +: PINS];
            a_oe_next      = {PINS{chain_q[bsdr_pkg::CH_A_DRV]}};
            b_oe_next      = {PINS{chain_q[bsdr_pkg::CH_B_DRV]}};
            core_a_next    = chain_q[bsdr_pkg::CH_AI_LO +: PINS];
            core_b_next    = chain_q[bsdr_pkg::CH_BI_LO +: PINS];
            core_ctrl_next = chain_q[bsdr_pkg::CH_CTRL_LO +: bsdr_pkg::CTRL_PINS];
        end else if (mode == bsdr_pkg::BSDR_MODE_HIGHZ) begin
            a_oe_next = '0;
            b_oe_next = '0;
        end
    end

    // Registered outputs; reset leaves pins released and normal path
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            byp_reg       <= 1'b0;
            tdo_reg       <= 1'b0;
            tdo_oe_reg    <= 1'b0;
            a_pin_reg     <= '0;
            b_pin_reg     <= '0;
            a_oe_reg      <= '0;
            b_oe_reg      <= '0;
            core_a_reg    <= '0;
            core_b_reg    <= '0;
            core_ctrl_reg <= '0;
        end else begin
            byp_reg       <= byp_next;
            tdo_reg       <= tdo_next;
            tdo_oe_reg    <= tdo_oe_next;
            a_pin_reg     <= a_pin_next;
            b_pin_reg     <= b_pin_next;
            a_oe_reg      <= a_oe_next;
            b_oe_reg      <= b_oe_next;
            core_a_reg    <= core_a_next;
            core_b_reg    <= core_b_next;
            core_ctrl_reg <= core_ctrl_next;
        end
    end

    assign tdo_o       = tdo_reg;
    assign tdo_oe_o    = tdo_oe_reg;
    assign a_pin_o     = a_pin_reg;
    assign b_pin_o     = b_pin_reg;
    assign a_pin_oe_o  = a_oe_reg;
    assign b_pin_oe_o  = b_oe_reg;
    assign core_a_o    = core_a_reg;
    assign core_b_o    = core_b_reg;
    assign core_ctrl_o = core_ctrl_reg;

    property p_tlr_reset;
        @(posedge mclk_i) disable iff (rst_i) tlr_i |=> chain_q == '0 && ctrl_q == 11'h002 && instr_q == 8'hff;
    endproperty
    a_tlr_reset: assert property (p_tlr_reset) else $error("reset values wrong after test-logic-reset");
    property p_ir_capture;
        @(posedge mclk_i) disable iff (rst_i) (tck_rise_i && cap_ir_i && !tlr_i) |=> instr_sh == 8'h81;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("instruction capture value wrong");
    property p_ir_update;
        @(posedge mclk_i) disable iff (rst_i) (tck_fall_i && upd_ir_i && !tlr_i) |=> instr_q == $past(instr_sh);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("instruction not updated on falling edge");
    property p_byp_capture;
        @(posedge mclk_i) disable iff (rst_i)
            (tck_rise_i && cap_dr_i && sel == bsdr_pkg::BSDR_SEL_BYPASS) |=> !byp_reg;
    endproperty
    a_byp_capture: assert property (p_byp_capture) else $error("bypass did not capture zero");
    property p_ctrl_hold;
        @(posedge mclk_i) disable iff (rst_i)
            (cap_dr_i && !sh_dr_i && !tlr_i && sel == bsdr_pkg::BSDR_SEL_CTRL) |=> $stable(ctrl_sh);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control register changed at capture");
    property p_chain_shift;
        @(posedge mclk_i) disable iff (rst_i)
            (tck_rise_i && sh_dr_i && !cap_dr_i && !tlr_i && sel == bsdr_pkg::BSDR_SEL_CHAIN)
            |=> chain_sh == {$past(tdi_i), $past(chain_sh[39:1])};
    endproperty
    a_chain_shift: assert property (p_chain_shift) else $error("chain shift order wrong");
    property p_oe_capture;
        @(posedge mclk_i) disable iff (rst_i)
            (tck_rise_i && cap_dr_i && !tlr_i && cap_kind == bsdr_pkg::BSDR_CAP_EXT
             && sel == bsdr_pkg::BSDR_SEL_CHAIN)
            |=> chain_sh[38] == $past(oea_eq) && chain_sh[39] == $past(oeb_eq);
    endproperty
    a_oe_capture: assert property (p_oe_capture) else $error("drive-enable cells captured wrong value");
    property p_test_pins;
        @(posedge mclk_i) disable iff (rst_i)
            (mode == bsdr_pkg::BSDR_MODE_TEST) |=> a_pin_o == $past(chain_q[23:16])
            && b_pin_oe_o == {8{$past(chain_q[39])}} && core_a_o == $past(chain_q[31:24]);
    endproperty
    a_test_pins: assert property (p_test_pins) else $error("test mode pins not from cells");
    property p_normal_pins;
        @(posedge mclk_i) disable iff (rst_i)
            (mode == bsdr_pkg::BSDR_MODE_NORMAL) |=> b_pin_o == $past(core_b_out_i) && core_b_o == $past(b_pin_i);
    endproperty
    a_normal_pins: assert property (p_normal_pins) else $error("normal path disturbed");
    property p_bypass_decode;
        @(posedge mclk_i) disable iff (rst_i)
            (instr_q == 8'h81 || instr_q == 8'hff) |-> sel == bsdr_pkg::BSDR_SEL_BYPASS
            && mode == bsdr_pkg::BSDR_MODE_NORMAL;
    endproperty
    a_bypass_decode: assert property (p_bypass_decode) else $error("bypass opcode decoded wrong");
endmodule
`default_nettype wire

//--- bsdr_tap_model.sv
// Test controller model: state levels, test-clock pulses, serial data
`timescale 1ns/1ps
`default_nettype none
module bsdr_tap_model (
    input  wire logic       mclk_i,
    input  wire logic       tdo_i,
    output var  logic       rise_o,
    output var  logic       fall_o,
    output var  logic [7:0] st_o,
    output var  logic       tdi_o
);
    logic smp;
    initial {rise_o, fall_o, st_o, tdi_o} = '0;
    // One test-clock period in a state; tdo read before the rising pulse
    task automatic step(input logic [7:0] s);
        st_o <= s;
        @(posedge mclk_i) fall_o <= 1'b1;
        @(posedge mclk_i) fall_o <= 1'b0;
        @(posedge mclk_i) smp = tdo_i;
        rise_o <= 1'b1;
        @(posedge mclk_i) rise_o <= 1'b0;
    endtask
    // lsb first, opcodes of either parity taken whole from the caller
    task automatic scan(input logic ir, input logic [39:0] din, input int n, output logic [39:0] dout);
        dout = '0;
        step(ir ? 8'h04 : 8'h20);
        for (int i = 0; i < n; i++) begin
            tdi_o <= din[i];
            step(ir ? 8'h02 : 8'h10);
            dout[i] = smp;
        end
        step(8'h00);
        step(ir ? 8'h01 : 8'h08);
        step(8'h00);
    endtask
endmodule
`default_nettype wire

//--- bsdr_top_tb.sv
// Self-checking bench for the boundary-scan data registers
`timescale 1ns/1ps
`default_nettype none
module bsdr_top_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [5:0] ctl = '1;
    logic [7:0] a_in = '0, b_in = '0, ca_in = '0, cb_in = '0;
    logic rise, fall, tdi, tdo, tdo_oe;
    logic [7:0] st, a_o, a_oe, b_o, b_oe, ca, cb;
    logic [5:0] cc;
    logic [39:0] q;
    int error_cnt = 0, total_checks = 0;
    // Expected external capture for the pin values set below
    localparam logic [39:0] CAP = {2'b10, 6'h1B, 8'h71, 8'h2E, 8'hD4, 8'h69};
    localparam logic [39:0] PAT = 40'h96_3CA5_5AC3;

    always #2 mclk_i = ~mclk_i;

    bsdr_tap_model u_tap (.mclk_i(mclk_i), .tdo_i(tdo), .rise_o(rise), .fall_o(fall), .st_o(st), .tdi_o(tdi));
    bsdr_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .tck_rise_i(rise), .tck_fall_i(fall), .tlr_i(st[7]),
        .rti_i(st[6]), .cap_dr_i(st[5]), .sh_dr_i(st[4]), .upd_dr_i(st[3]), .cap_ir_i(st[2]), .sh_ir_i(st[1]),
        .upd_ir_i(st[0]), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ab_output_enable_n_i(ctl[5]),
        .ba_output_enable_n_i(ctl[4]), .ab_latch_enable_n_i(ctl[3]), .ba_latch_enable_n_i(ctl[2]),
        .ab_chip_enable_n_i(ctl[1]), .ba_chip_enable_n_i(ctl[0]), .a_pin_i(a_in), .a_pin_o(a_o),
        .a_pin_oe_o(a_oe), .b_pin_i(b_in), .b_pin_o(b_o), .b_pin_oe_o(b_oe), .core_a_out_i(ca_in),
        .core_b_out_i(cb_in), .core_a_o(ca), .core_b_o(cb), .core_ctrl_o(cc));

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ir(input logic [7:0] op);
        u_tap.scan(1'b1, {32'h0, op}, 8, q);
    endtask
    task automatic dr(input logic [39:0] d, input int n);
        u_tap.scan(1'b0, d, n, q);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Control register: reset value, hold at capture, scan order
    task automatic t_ctrl;
        ir(8'h8E); chk(q, 40'h81);
        dr(40'h5A3, 11); chk(q, 40'h002);
        dr(40'h0, 11); chk(q, 40'h5A3);
        ir(8'h0F); dr(40'h2, 11); chk(q, 40'h0);
        $display("test ctrl done");
    endtask
    // Bypass-path opcodes, unlisted ones and the odd-parity 01 among them
    task automatic t_bypass;
        logic [7:0] ops [10] = '{8'h81, 8'h84, 8'h05, 8'h88, 8'h01, 8'hFF, 8'h87, 8'h09, 8'h8D, 8'h06};
        foreach (ops[i]) begin
            ir(ops[i]); dr(40'hB, 4); chk(q, 40'h6);
        end
        chk({a_oe, b_oe}, 40'h0);
        $display("test bypass done");
    endtask
    // Test-mode chain: capture sources, then cells drive pins and core
    task automatic t_chain;
        logic [7:0] ops [2] = '{8'h00, 8'h03};
        foreach (ops[i]) begin
            ir(ops[i]); dr(PAT, 40); chk(q, CAP);
            chk({b_o, b_oe, a_oe, a_o, ca}, {8'hC3, 8'hFF, 8'h00, 8'hA5, 8'h3C});
            chk({cb, cc}, {8'h5A, 6'h16});
        end
        $display("test chain done");
    endtask
    // Run-test steps: none under clamp, then toggle, then signature of A inputs
    task automatic t_run;
        ir(8'h87); u_tap.step(8'h40); u_tap.step(8'h40); chk(b_o, 8'hC3);
        ir(8'h8D); u_tap.step(8'h40); u_tap.step(8'h40); chk({b_o, a_o}, 16'h3CA5);
        ir(8'h09); u_tap.step(8'h40); u_tap.step(8'h40); chk({ca, b_o}, 16'h09C3);
        $display("test run done");
    endtask
    // Reset state clears the chain; read and sample in normal mode
    task automatic t_reset;
        u_tap.step(8'h80);
        ir(8'h0A); dr(40'h0, 40); chk(q, 40'h0);
        ir(8'h82); dr(40'h0, 40); chk(q, CAP);
        chk({b_o, b_oe}, {8'h69, 8'hFF});
        ir(8'h0C); dr(40'h0, 40); chk(q, 40'hFF_FFFF_FFFF);
        u_tap.step(8'h02); chk(tdo_oe, 1'b1); u_tap.step(8'h00); chk(tdo_oe, 1'b0);
        $display("test reset done");
    endtask

    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        {ctl, a_in, ca_in, b_in, cb_in} <= {6'h1B, 8'h71, 8'h2E, 8'hD4, 8'h69};
        t_ctrl;
        t_bypass;
        t_chain;
        t_run;
        t_reset;
        close_out;
    end
    // Hang guard
    initial begin
        repeat (50000) @(posedge mclk_i);
        error_cnt++;
        close_out;
    end
endmodule
`default_nettype wire
